/* File: radio_cmd_pkg.sv */
// shared constants, codes and carrier types of the serial command block
package radio_cmd_pkg;

   // ****************************************
   // command codes and reset values
   // ****************************************
   localparam logic [7:0] AFA_CODE = 8'hC4;
   localparam logic [6:0] TXCFG_CODE = 7'h4C;
   localparam logic [7:0] TXDATA_CODE = 8'hB8;
   localparam logic [7:0] CONFIG_CODE = 8'h80;
   localparam int CMD_FLAG_BIT = 15;
   localparam int CFG_DATA_REG_BIT = 7;
   localparam logic [7:0] AFA_RESET = 8'h00;
   localparam logic [8:0] TXCFG_RESET = 9'h000;
   localparam logic [7:0] TXBYTE_RESET = 8'hAA;
   localparam logic [3:0] WORD_LAST = 4'hF;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [2:0] TX_LAST_BIT = 3'h7;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLOCK_MHZ = 200;
   localparam int AFA_SAMPLE_NS = 1000;
   localparam int AFA_CYCLES = (AFA_SAMPLE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int TX_BIT_NS = 4000;
   localparam int TX_BIT_CYCLES = (TX_BIT_NS * CLOCK_MHZ) / 1000;

   // ****************************************
   // modes, ranges, bands and scales
   // ****************************************
   localparam logic [1:0] ADJ_OFF = 2'h0;
   localparam logic [1:0] ADJ_ONCE = 2'h1;
   localparam logic [1:0] ADJ_CLEAR_NO_VDI = 2'h2;
   localparam logic [1:0] ADJ_KEEP = 2'h3;
   localparam logic [1:0] RANGE_NONE = 2'h0;
   localparam logic [1:0] RANGE_16 = 2'h1;
   localparam logic [1:0] RANGE_8 = 2'h2;
   localparam logic [1:0] RANGE_4 = 2'h3;
   localparam logic [1:0] BAND_LOW = 2'h1;
   localparam logic [1:0] BAND_MID = 2'h2;
   localparam logic [1:0] BAND_HIGH = 2'h3;
   localparam logic [15:0] FRES_LOW_HZ = 16'h09C4;
   localparam logic [15:0] FRES_MID_HZ = 16'h1388;
   localparam logic [15:0] FRES_HIGH_HZ = 16'h1D4C;
   localparam int DEV_STEP_KHZ = 15;
   localparam int PWR_STEP_DB = 3;

   // ****************************************
   // carrier types and states
   // ****************************************
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] range;
      logic strobe;
      logic fine;
      logic apply;
      logic calc;
   } afa_ctrl_s;

   typedef struct packed {
      logic pol;
      logic [3:0] dev;
      logic unused;
      logic [2:0] pwr;
   } tx_cfg_s;

   typedef struct packed {
      logic is_byte;
      logic [15:0] bits;
   } link_word_s;

   typedef enum logic [1:0] {MEAS_IDLE = 2'b00, MEAS_RUN = 2'b01, MEAS_DONE = 2'b11} meas_state_e;
   typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_e;

endpackage : radio_cmd_pkg

/* File: radio_cmd_regs.sv */
// serial command receiver, frequency adjust unit and transmit byte path
`timescale 1ns/1ps

// Notes on behaviour
// - mode 1,0 clears offset while indicator low
// - mode 1,1 keeps offset regardless of indicator
// - range code clamps offset to step limits
// - step is 2.5, 5, 7.5 kHz by band
// - strobe bit starts one manual offset sample
// - fine bit doubles measurement time
// - apply bit adds offset to control word
// - offset computed only while calc enabled
// - seven-bit code loads transmit configuration
// - polarity bit swaps high and low frequency
// - deviation is 15 kHz times code plus one
// - power drops 3 dB per code step
// - eight-bit code loads next transmit byte
// - byte register used only when enabled
// - transmit byte resets to 0xAA
// - transmitter enable starts sending held byte
// - serial output high when register empty
// - streaming keeps select low, one command
// - further bytes in frame load transmit register
// - mode 0,1 measures once, 0,0 off
// - underrun or overwrite flag, cleared on status
// - auto modes sample on indicator rising
module radio_cmd_regs (
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire logic SPI_SCK_I,
   input wire logic SPI_CS_N_I,
   input wire logic SPI_SDI_I,
   output logic SDO_O,
   input wire logic DATA_REG_EN_I,
   input wire logic TX_ENABLE_I,
   input wire logic [1:0] BAND_I,
   input wire logic VDI_I,
   input wire logic DATA_PIN_I,
   input wire logic signed [7:0] RAW_OFFSET_I,
   output logic signed [7:0] OFFSET_O,
   output logic signed [7:0] FCW_ADJ_O,
   output logic signed [23:0] OFFSET_HZ_O,
   output logic MEAS_BUSY_O,
   output logic FREQ_HIGH_O,
   output logic [7:0] DEVIATION_KHZ_O,
   output logic [4:0] POWER_ATTEN_DB_O,
   output logic TX_ACTIVE_O,
   output logic UNDERRUN_O
);
   import radio_cmd_pkg::*;

   // ****************************************
   // link side, clocked by the serial clock
   // ****************************************
   logic [3:0] bit_cnt;
   logic stream;
   logic [14:0] shift;
   logic word_tgl;
   link_word_s link_word;
   wire link_clr = SPI_CS_N_I | RESET_I;
   wire [15:0] next_word = {shift, SPI_SDI_I};
   wire word_end = !stream && (bit_cnt == WORD_LAST);
   wire byte_end = stream && (bit_cnt == BYTE_LAST);
   wire enter_stream = word_end && (next_word[15:8] == TXDATA_CODE);

   // frame state dies with the select going high
   always_ff @(posedge SPI_SCK_I or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt <= 4'h0;
         stream <= 1'b0;
         shift <= 15'h0000;
      end else begin
         shift <= next_word[14:0];
         bit_cnt <= byte_end ? 4'h0 : bit_cnt + 4'h1;
         if (enter_stream) begin
            stream <= 1'b1;
         end
      end
   end

   // finished word or streamed byte is held until the next one
   always_ff @(posedge SPI_SCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         word_tgl <= 1'b0;
         link_word <= '0;
      end else if (word_end || byte_end) begin
         word_tgl <= ~word_tgl;
         link_word.is_byte <= byte_end;
         link_word.bits <= byte_end ? {8'h00, next_word[7:0]} : next_word;
      end
   end

   // ****************************************
   // crossing into the system clock
   // ****************************************
   logic tgl_s1, tgl_s2, tgl_s3;
   logic vdi_s1, vdi_s2, vdi_d;
   logic pin_s1, pin_s2;

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
         vdi_s1 <= 1'b0;
         vdi_s2 <= 1'b0;
         vdi_d <= 1'b0;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end else begin
         tgl_s1 <= word_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
         vdi_s1 <= VDI_I;
         vdi_s2 <= vdi_s1;
         vdi_d <= vdi_s2;
         pin_s1 <= DATA_PIN_I;
         pin_s2 <= pin_s1;
      end
   end

   // ****************************************
   // command decode
   // ****************************************
   wire word_ev = tgl_s2 ^ tgl_s3;
   wire is_cmd = word_ev && !link_word.is_byte;
   wire hit_afa = is_cmd && (link_word.bits[15:8] == AFA_CODE);
   wire hit_txcfg = is_cmd && (link_word.bits[15:9] == TXCFG_CODE);
   wire hit_byte = word_ev && (link_word.is_byte || link_word.bits[15:8] == TXDATA_CODE);
   wire hit_status = is_cmd && !link_word.bits[CMD_FLAG_BIT];
   wire vdi_rise = vdi_s2 && !vdi_d;

   afa_ctrl_s afa;
   tx_cfg_s txcfg;
   logic [7:0] txbyte;
   logic strobe_d;

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         afa <= AFA_RESET;
         txcfg <= TXCFG_RESET;
         txbyte <= TXBYTE_RESET;
         strobe_d <= 1'b0;
      end else begin
         strobe_d <= afa.strobe;
         if (hit_afa) begin
            afa <= link_word.bits[7:0];
         end
         if (hit_txcfg) begin
            txcfg <= link_word.bits[8:0];
         end
         if (hit_byte) begin
            txbyte <= link_word.bits[7:0];
         end
      end
   end

   // ****************************************
   // frequency adjust unit
   // ****************************************
   meas_state_e meas_state, next_meas_state;
   logic [15:0] meas_timer;
   logic fine_lat;
   logic once_pending;
   logic signed [7:0] offset;
   logic [15:0] run_len;

   wire auto_mode = afa.mode[1];
   wire strobe_rise = afa.strobe && !strobe_d;
   wire auto_start = auto_mode && vdi_rise;
   wire once_start = (afa.mode == ADJ_ONCE) && once_pending;
   wire meas_start = afa.calc && (strobe_rise || auto_start || once_start);
   wire [15:0] start_len = afa.fine ? 16'(2 * AFA_CYCLES) : 16'(AFA_CYCLES);
   wire clear_no_vdi = (afa.mode == ADJ_CLEAR_NO_VDI) && !vdi_s2;

   function automatic logic signed [7:0] clamp(input logic signed [7:0] v, input logic [1:0] rng);
      logic signed [7:0] hi;
      logic signed [7:0] lo;
      hi = 8'sd127;
      lo = -8'sd128;
      unique case (rng)
         RANGE_NONE: begin
            hi = 8'sd127;
            lo = -8'sd128;
         end
         RANGE_16: begin
            hi = 8'sd15;
            lo = -8'sd16;
         end
         RANGE_8: begin
            hi = 8'sd7;
            lo = -8'sd8;
         end
         RANGE_4: begin
            hi = 8'sd3;
            lo = -8'sd4;
         end
      endcase
      clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction : clamp

   always_comb begin
      next_meas_state = meas_state;
      unique case (meas_state)
         MEAS_IDLE: begin
            if (meas_start) begin
               next_meas_state = MEAS_RUN;
            end
         end
         MEAS_RUN: begin
            if (!afa.calc) begin
               next_meas_state = MEAS_IDLE;
            end else if (meas_timer == 16'h0001) begin
               next_meas_state = MEAS_DONE;
            end
         end
         MEAS_DONE: begin
            next_meas_state = MEAS_IDLE;
         end
         default: begin
            next_meas_state = MEAS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         meas_state <= MEAS_IDLE;
         meas_timer <= 16'h0000;
         fine_lat <= 1'b0;
         once_pending <= 1'b1;
         offset <= 8'sd0;
         run_len <= 16'h0000;
      end else begin
         meas_state <= next_meas_state;
         if (meas_state == MEAS_IDLE && meas_start) begin
            meas_timer <= start_len;
            fine_lat <= afa.fine;
            run_len <= 16'h0000;
            once_pending <= once_pending && !once_start;
         end else if (meas_state == MEAS_RUN) begin
            meas_timer <= meas_timer - 16'h0001;
            run_len <= run_len + 16'h0001;
         end
         if (clear_no_vdi) begin
            offset <= 8'sd0;
         end else if (next_meas_state == MEAS_DONE) begin
            offset <= clamp(RAW_OFFSET_I, afa.range);
         end
      end
   end

   logic signed [15:0] fres;
   always_comb begin
      unique case (BAND_I)
         BAND_LOW: fres = FRES_LOW_HZ;
         BAND_MID: fres = FRES_MID_HZ;
         BAND_HIGH: fres = FRES_HIGH_HZ;
         default: fres = 16'sh0000;
      endcase
   end

   // ****************************************
   // transmit byte path
   // ****************************************
   tx_state_e tx_state;
   logic [7:0] tx_shift;
   logic [2:0] tx_bit;
   logic [15:0] tx_timer;
   logic tx_empty;
   logic underrun;

   wire tx_go = TX_ENABLE_I && DATA_REG_EN_I;
   wire bit_end = (tx_state == TX_SEND) && (tx_timer == 16'(TX_BIT_CYCLES - 1));
   wire byte_done = bit_end && (tx_bit == TX_LAST_BIT);
   wire [7:0] load_byte = hit_byte ? link_word.bits[7:0] : txbyte;
   wire reload = (tx_state == TX_IDLE && tx_go) || (byte_done && tx_go);
   wire tx_fault = (byte_done && tx_empty && !hit_byte) || (hit_byte && !tx_empty && tx_state == TX_SEND && !reload);
   wire data_bit = DATA_REG_EN_I ? tx_shift[7] : pin_s2;

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         tx_state <= TX_IDLE;
         tx_shift <= TXBYTE_RESET;
         tx_bit <= 3'h0;
         tx_timer <= 16'h0000;
         tx_empty <= 1'b0;
         underrun <= 1'b0;
      end else begin
         underrun <= tx_fault || (underrun && !hit_status);
         if (!tx_go) begin
            tx_state <= TX_IDLE;
            tx_empty <= 1'b0;
         end else if (reload) begin
            tx_state <= TX_SEND;
            tx_shift <= load_byte;
            tx_bit <= 3'h0;
            tx_timer <= 16'h0000;
            tx_empty <= 1'b1;
         end else begin
            tx_timer <= bit_end ? 16'h0000 : tx_timer + 16'h0001;
            if (bit_end) begin
               tx_shift <= {tx_shift[6:0], 1'b0};
               tx_bit <= tx_bit + 3'h1;
            end
            if (hit_byte) begin
               tx_empty <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         OFFSET_O <= 8'sd0;
         FCW_ADJ_O <= 8'sd0;
         OFFSET_HZ_O <= 24'sd0;
         MEAS_BUSY_O <= 1'b0;
         FREQ_HIGH_O <= 1'b0;
         DEVIATION_KHZ_O <= 8'h00;
         POWER_ATTEN_DB_O <= 5'h00;
         TX_ACTIVE_O <= 1'b0;
         UNDERRUN_O <= 1'b0;
         SDO_O <= 1'b0;
      end else begin
         OFFSET_O <= offset;
         FCW_ADJ_O <= afa.apply ? offset : 8'sd0;
         OFFSET_HZ_O <= offset * fres;
         MEAS_BUSY_O <= meas_state != MEAS_IDLE;
         FREQ_HIGH_O <= data_bit ^ txcfg.pol;
         DEVIATION_KHZ_O <= 8'(DEV_STEP_KHZ * (32'(txcfg.dev) + 1));
         POWER_ATTEN_DB_O <= 5'(PWR_STEP_DB * 32'(txcfg.pwr));
         TX_ACTIVE_O <= tx_state == TX_SEND;
         UNDERRUN_O <= underrun;
         SDO_O <= tx_empty && tx_state == TX_SEND;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   sequence meas_launch;
      meas_state == MEAS_IDLE && meas_start ##1 meas_state == MEAS_RUN;
   endsequence

   a_mode10_clear: assert property (clear_no_vdi |=> offset == 8'sd0 ##1 OFFSET_O == 8'sd0)
      else $error("offset not cleared with indicator low");
   a_mode11_keep: assert property ((afa.mode == ADJ_KEEP) && !$rose(vdi_s2) && next_meas_state != MEAS_DONE
      |=> $stable(offset))
      else $error("kept offset changed");
   a_range_clamp: assert property (next_meas_state == MEAS_DONE && afa.range == RANGE_4
      |=> offset <= 8'sd3 && offset >= -8'sd4)
      else $error("offset outside narrow range");
   a_band_scale: assert property (BAND_I == BAND_MID |=> OFFSET_HZ_O == $past(offset) * 24'sd5000)
      else $error("offset scaling wrong");
   a_strobe_start: assert property (meas_state == MEAS_IDLE && strobe_rise && afa.calc |-> meas_launch)
      else $error("strobe did not start a sample");
   a_fine_time: assert property (meas_state == MEAS_DONE
      |-> run_len == (fine_lat ? 16'(2 * AFA_CYCLES) : 16'(AFA_CYCLES)))
      else $error("measurement length wrong");
   a_apply_gate: assert property (!afa.apply |=> FCW_ADJ_O == 8'sd0)
      else $error("offset applied while disabled");
   a_calc_gate: assert property (!afa.calc |=> meas_state != MEAS_RUN ##1 !MEAS_BUSY_O || !$past(afa.calc))
      else $error("measurement without calc enable");
   a_txcfg_load: assert property (hit_txcfg |=> txcfg == $past(link_word.bits[8:0]))
      else $error("transmit configuration not loaded");
   a_dev_khz: assert property (hit_txcfg && link_word.bits[7:4] == 4'hF |=> ##1 DEVIATION_KHZ_O == 8'd240)
      else $error("deviation code wrong");
   a_byte_load: assert property (hit_byte && !reload |=> txbyte == $past(link_word.bits[7:0]))
      else $error("transmit byte not loaded");
   a_ready_sdo: assert property (tx_go && tx_state == TX_IDLE |=> tx_state == TX_SEND ##1 SDO_O)
      else $error("transmit did not start with ready shown");
   a_underrun_flag: assert property (tx_fault |=> underrun ##1 UNDERRUN_O)
      else $error("underrun not flagged");

endmodule : radio_cmd_regs

/* File: spi_host_model.sv */
// host side of the serial command link
`timescale 1ns/1ps
module spi_host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic sdi_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   // ********
   // framing
   // ********
   task automatic open_frame();
      #1.3;
      cs_n_o = 1'b0;
      #80;
   endtask : open_frame
   task automatic shift_bit(input logic b);
      sdi_o = b;
      #80;
      sck_o = 1'b1;
      #80;
      sck_o = 1'b0;
   endtask : shift_bit
   task automatic shift16(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) shift_bit(w[i]);
   endtask : shift16
   task automatic shift8(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) shift_bit(b[i]);
   endtask : shift8
   task automatic close_frame();
      #80;
      cs_n_o = 1'b1;
      // released line must not keep showing the last bit
      sdi_o = ~sdi_o;
      #80;
   endtask : close_frame
   task automatic send_word(input logic [15:0] w);
      open_frame();
      shift16(w);
      close_frame();
   endtask : send_word
endmodule : spi_host_model

/* File: tx_and_freq_adjust_cmds_tb.sv */
// self-checking bench of the command, adjust and transmit block
`timescale 1ns/1ps
module tx_and_freq_adjust_cmds_tb;
   import radio_cmd_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic data_reg_en = 1'b0;
   logic tx_enable = 1'b0;
   logic [1:0] band = BAND_MID;
   logic valid_data_indicator = 1'b0;
   logic data_pin = 1'b0;
   logic signed [7:0] raw = 8'sh00;
   logic sck, cs_n, sdi, sdo, busy, freq_high, tx_active, underrun;
   logic signed [7:0] offset, fcw;
   logic signed [23:0] offset_hz;
   logic [7:0] dev_khz;
   logic [4:0] atten;
   int n_errors = 0;
   int samples_checked = 0;
   int busy_cnt = 0;

   always #2.5 clock = ~clock;
   always @(posedge clock) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

   spi_host_model spi_host_model_i (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));
   radio_cmd_regs radio_cmd_regs_i (
      .CLOCK_I(clock),
      .RESET_I(reset),
      .SPI_SCK_I(sck),
      .SPI_CS_N_I(cs_n),
      .SPI_SDI_I(sdi),
      .SDO_O(sdo),
      .DATA_REG_EN_I(data_reg_en),
      .TX_ENABLE_I(tx_enable),
      .BAND_I(band),
      .VDI_I(valid_data_indicator),
      .DATA_PIN_I(data_pin),
      .RAW_OFFSET_I(raw),
      .OFFSET_O(offset),
      .FCW_ADJ_O(fcw),
      .OFFSET_HZ_O(offset_hz),
      .MEAS_BUSY_O(busy),
      .FREQ_HIGH_O(freq_high),
      .DEVIATION_KHZ_O(dev_khz),
      .POWER_ATTEN_DB_O(atten),
      .TX_ACTIVE_O(tx_active),
      .UNDERRUN_O(underrun)
   );

   // ********
   // helpers
   // ********
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic wait_for(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim && s !== v; i++) cyc(1);
   endtask : wait_for
   task automatic afa(input logic [1:0] m, r, input logic st, fi, ap, ca);
      afa_ctrl_s c;
      c = '{mode: m, range: r, strobe: st, fine: fi, apply: ap, calc: ca};
      spi_host_model_i.send_word({AFA_CODE, c});
   endtask : afa
   task automatic measure(input logic [1:0] r, b, input logic fi, ap, input int rv, lim, fres);
      int n;
      n = fi ? 2 * AFA_CYCLES : AFA_CYCLES;
      @(posedge clock) band <= b;
      raw <= 8'(rv);
      afa(ADJ_KEEP, r, 1'b0, fi, ap, 1'b1);
      busy_cnt = 0;
      afa(ADJ_KEEP, r, 1'b1, fi, ap, 1'b1);
      wait_for(busy, 1'b0, 1000);
      cyc(4);
      check("busy time", 32'(busy_cnt >= n - 1 && busy_cnt <= n + 1), 32'h1);
      check("offset", 32'(offset), 32'(lim));
      check("control word", 32'(fcw), ap ? 32'(lim) : 32'h0);
      check("offset hz", 32'(offset_hz), 32'(lim * fres));
   endtask : measure
   task automatic txbits(input logic [7:0] b);
      for (int k = 7; k >= 0; k--) begin
         cyc(k == 7 ? 400 : 800);
         check("tx bit", 32'(freq_high), 32'(b[k]));
      end
   endtask : txbits

   // ********
   // scenarios
   // ********
   task automatic test_reset();
      check("ready", 32'(sdo), 32'h0);
      check("offset", 32'(offset), 32'h0);
      check("deviation", 32'(dev_khz), 32'hF);
      $display("reset test done");
   endtask : test_reset
   task automatic test_tx_config();
      tx_cfg_s c;
      for (int d = 0; d < 16; d++) begin
         c = '{pol: d[1], dev: 4'(d), unused: 1'b0, pwr: 3'(d)};
         @(posedge clock) data_pin <= d[0];
         spi_host_model_i.send_word({TXCFG_CODE, c});
         cyc(6);
         check("deviation", 32'(dev_khz), 32'(15 * (d + 1)));
         check("attenuation", 32'(atten), 32'(3 * (d % 8)));
         check("freq high", 32'(freq_high), 32'(d[0] ^ d[1]));
      end
      spi_host_model_i.send_word(16'hC800);
      cyc(6);
      check("ignored code", 32'(dev_khz), 32'hF0);
      $display("tx config test done");
   endtask : test_tx_config
   task automatic test_adjust();
      measure(RANGE_NONE, BAND_LOW, 1'b0, 1'b1, -100, -100, 2500);
      measure(RANGE_16, BAND_MID, 1'b1, 1'b1, -100, -16, 5000);
      measure(RANGE_8, BAND_HIGH, 1'b0, 1'b0, -100, -8, 7500);
      measure(RANGE_4, BAND_LOW, 1'b0, 1'b1, -100, -4, 2500);
      measure(RANGE_16, BAND_MID, 1'b0, 1'b1, 100, 15, 5000);
      measure(RANGE_4, BAND_HIGH, 1'b1, 1'b1, 100, 3, 7500);
      busy_cnt = 0;
      afa(ADJ_KEEP, RANGE_4, 1'b1, 1'b1, 1'b1, 1'b1);
      cyc(300);
      check("strobe held", 32'(busy_cnt), 32'h0);
      $display("adjust test done");
   endtask : test_adjust
   task automatic test_indicator();
      @(posedge clock) raw <= 8'sh02;
      afa(ADJ_KEEP, RANGE_NONE, 1'b0, 1'b0, 1'b1, 1'b1);
      @(posedge clock) valid_data_indicator <= 1'b1;
      cyc(30);
      wait_for(busy, 1'b0, 1000);
      cyc(4);
      check("offset on indicator", 32'(offset), 32'h2);
      @(posedge clock) valid_data_indicator <= 1'b0;
      cyc(20);
      check("offset kept", 32'(offset), 32'h2);
      afa(ADJ_CLEAR_NO_VDI, RANGE_NONE, 1'b0, 1'b0, 1'b1, 1'b1);
      cyc(10);
      check("offset cleared", 32'(offset), 32'h0);
      afa(ADJ_KEEP, RANGE_NONE, 1'b0, 1'b0, 1'b1, 1'b0);
      busy_cnt = 0;
      @(posedge clock) valid_data_indicator <= 1'b1;
      raw <= 8'sh05;
      cyc(300);
      check("no calc", 32'(busy_cnt), 32'h0);
      check("offset still", 32'(offset), 32'h0);
      @(posedge clock) valid_data_indicator <= 1'b0;
      afa(ADJ_ONCE, RANGE_NONE, 1'b0, 1'b0, 1'b1, 1'b1);
      cyc(30);
      wait_for(busy, 1'b0, 1000);
      cyc(4);
      check("offset once", 32'(offset), 32'h5);
      @(posedge clock) raw <= 8'sh07;
      afa(ADJ_ONCE, RANGE_NONE, 1'b0, 1'b0, 1'b1, 1'b1);
      cyc(300);
      check("offset once only", 32'(offset), 32'h5);
      $display("indicator test done");
   endtask : test_indicator
   task automatic test_transmit();
      spi_host_model_i.send_word({TXCFG_CODE, 9'h000});
      spi_host_model_i.send_word({TXDATA_CODE, 8'hAA});
      @(posedge clock) data_reg_en <= 1'b1;
      tx_enable <= 1'b1;
      cyc(3);
      check("ready", 32'(sdo), 32'h1);
      check("sending", 32'(tx_active), 32'h1);
      fork
         txbits(8'hAA);
         begin
            spi_host_model_i.open_frame();
            spi_host_model_i.shift16({TXDATA_CODE, 8'h3C});
            cyc(8);
            check("loaded", 32'(sdo), 32'h0);
         end
      join
      wait_for(sdo, 1'b1, 1000);
      check("ready again", 32'(sdo), 32'h1);
      txbits(8'h3C);
      spi_host_model_i.shift8(8'h5A);
      cyc(8);
      check("stream loaded", 32'(sdo), 32'h0);
      spi_host_model_i.close_frame();
      wait_for(sdo, 1'b1, 1000);
      txbits(8'h5A);
      cyc(500);
      check("underrun", 32'(underrun), 32'h1);
      spi_host_model_i.send_word(16'h0000);
      cyc(8);
      check("underrun cleared", 32'(underrun), 32'h0);
      @(posedge clock) tx_enable <= 1'b0;
      data_reg_en <= 1'b0;
      $display("transmit test done");
   endtask : test_transmit

   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      cyc(6);
      test_reset();
      test_tx_config();
      test_adjust();
      test_indicator();
      test_transmit();
      summarize();
   end
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
endmodule : tx_and_freq_adjust_cmds_tb
